// >>> shared/ecc_pkg.sv
package ecc_pkg;

    // Counter geometry.
    localparam int CNT_W = 24;
    localparam logic [23:0] CNT_MAX = 24'hFFFFFF;
    localparam logic [23:0] CNT_ZERO = 24'h000000;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_PRESET = 8'h00;
    localparam logic [7:0] IDX_CONTROL = 8'h03;
    localparam logic [7:0] IDX_COUNT = 8'h05;
    localparam logic [7:0] IDX_COMMAND = 8'h06;

    // Control register field positions.
    localparam int POS_IDX_ACT = 22;
    localparam int POS_IDX_INV = 21;
    localparam int POS_IDX_EN = 20;
    localparam int POS_DIR_INV = 19;
    localparam int POS_ENABLE = 18;
    localparam int POS_LIMIT_HI = 17;
    localparam int POS_LIMIT_LO = 16;
    localparam int POS_MODE_HI = 15;
    localparam int POS_MODE_LO = 14;

    // Command and count register field positions.
    localparam int POS_CMD_RESET = 0;
    localparam int POS_STAT_FROZEN = 24;
    localparam int POS_STAT_DIR = 25;

    // Reset values and the mask of implemented control bits.
    localparam logic [31:0] CONTROL_RESET = 32'h00000000;
    localparam logic [31:0] CONTROL_MASK = 32'h007FC000;
    localparam logic [23:0] PRESET_RESET = 24'h000000;

    // Counter limit behaviour.
    typedef enum logic [1:0] {
        ECC_LIM_WRAP = 2'b00,
        ECC_LIM_CLAMP = 2'b01,
        ECC_LIM_FREEZE = 2'b10,
        ECC_LIM_MODN = 2'b11
    } ecc_limit_t;

    // Input decoding mode.
    typedef enum logic [1:0] {
        ECC_MODE_CLKDIR = 2'b00,
        ECC_MODE_SINGLE_EDGE_QUAD = 2'b01,
        ECC_MODE_DOUBLE_EDGE_QUAD = 2'b10,
        ECC_MODE_QUAD_EDGE_QUAD = 2'b11
    } ecc_mode_t;

endpackage : ecc_pkg

// >>> shared/ecc_step_if.sv
`timescale 1ns/1ps
// Count request from the phase decoder to the counter.
interface ecc_step_if;
    logic step;
    logic up;
    modport src(output step, output up);
    modport dst(input step, input up);
endinterface : ecc_step_if

// >>> verilog/ecc_sync.sv
`timescale 1ns/1ps
module ecc_sync (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic nrst_in,
    // Raw pin and filtered level.
    input wire logic raw_in,
    output logic level_out
);

    logic stage1;
    logic stage2;
    logic stage3;

    // Three flops; the level moves only when the last two agree, which rejects one-cycle glitches.
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
            level_out <= 1'b0;
        end else begin
            stage1 <= raw_in;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                level_out <= stage3;
            end
        end
    end

endmodule : ecc_sync

// >>> verilog/ecc_decoder.sv
`timescale 1ns/1ps
module ecc_decoder (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic nrst_in,
    // Filtered phase levels.
    input wire logic phase_a_in,
    input wire logic phase_b_in,
    // Configuration.
    input wire ecc_pkg::ecc_mode_t mode_in,
    input wire logic dir_invert_in,
    // Count request.
    ecc_step_if.src step_if
);
    import ecc_pkg::*;

    logic prev_a;
    logic prev_b;
    logic a_chg;
    logic b_chg;
    logic a_rise;
    logic quad_up;
    logic raw_step;
    logic raw_up;

    // Previous levels; tracked even while disabled so re-enabling gives no false step.
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            prev_a <= 1'b0;
            prev_b <= 1'b0;
        end else begin
            prev_a <= phase_a_in;
            prev_b <= phase_b_in;
        end
    end

    // Edge terms; a move of both phases at once is illegal in the quadrature modes and is ignored there.
    assign a_chg = phase_a_in ^ prev_a;
    assign b_chg = phase_b_in ^ prev_b;
    assign a_rise = phase_a_in & ~prev_a;
    assign quad_up = ~(prev_a ^ phase_b_in);

    // Step selection per decoding mode.
    assign raw_step = (mode_in == ECC_MODE_CLKDIR) ? a_rise :
        (mode_in == ECC_MODE_SINGLE_EDGE_QUAD) ? (a_rise & ~b_chg) :
        (mode_in == ECC_MODE_DOUBLE_EDGE_QUAD) ? (a_chg & ~b_chg) :
        (a_chg ^ b_chg);
    assign raw_up = (mode_in == ECC_MODE_CLKDIR) ? phase_b_in : quad_up;

    // The invert bit swaps direction in every mode.
    assign step_if.step = raw_step;
    assign step_if.up = raw_up ^ dir_invert_in;

endmodule : ecc_decoder

// >>> verilog/ecc_top.sv
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - Index-enable bit 20 set lets index reset or preset; clear ignores index.
// - Quadrature: A leading B counts up, B leading A down; bit 19 swaps.
// - Clock/direction: B high counts up, low down; invert bit swaps this.
// - Encoder inputs count only while enable bit 18 is one.
// - Limit 00: free 24-bit counter wrapping between 0 and 16777215.
// - Limit 01: hold at 0 or preset; resume on motion back inside.
// - Limit 10: freeze at 0 going down or preset going up until reset.
// - Limit 11: modulo-N, up rolls over to 0 after matching preset, down rolls from 0 to preset.
// - Limit field sits at bits 17:16, decode mode at bits 15:14.
// - Mode 00: A rising edge counts one, direction from B level.
// - Mode 01: one count per four quadrature state changes.
// - Mode 10: one count per two quadrature state changes.
// - Mode 11: one count per quadrature state change.
// - Index action bit 22: set loads preset, clear resets to zero.
// - Preset low 24 bits give modulo roll-over and clamp/freeze upper bound.
module ecc_top (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic nrst_in,
    // APB slave.
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Encoder pins.
    input wire logic phase_a_in,
    input wire logic phase_b_in,
    input wire logic index_in
);
    import ecc_pkg::*;

    // Word address match for a register index.
    function automatic logic ecc_hit(input logic [7:0] addr, input logic [7:0] idx);
        return addr == {idx[5:0], 2'b00};
    endfunction : ecc_hit

    // Value one step away, wrapping at the 24-bit ends.
    function automatic logic [23:0] ecc_next(input logic [23:0] c, input logic up);
        return up ? (c + 24'h000001) : (c - 24'h000001);
    endfunction : ecc_next

    logic [23:0] preset;
    logic [31:0] ctl;
    logic [23:0] count;
    logic frozen;
    logic last_up;
    logic [23:0] next_count;
    logic next_frozen;
    logic a_lvl;
    logic b_lvl;
    logic idx_lvl;
    logic idx_prev;
    logic idx_edge;
    logic idx_hit;
    logic cnt_go;
    logic chan_reset;
    logic enable;
    logic dir_inv;
    logic idx_en;
    logic idx_act;
    logic idx_inv;
    ecc_limit_t limit;
    ecc_mode_t mode;
    logic [23:0] stepv;
    logic [23:0] bound;
    logic setup;
    logic access;
    logic wr;
    logic sel_preset;
    logic sel_control;
    logic sel_count;
    logic sel_command;
    logic mapped;
    logic [31:0] status_word;
    logic [31:0] rd_value;

    ecc_step_if step_bus();

    // Each pin passes its own three-flop filter.
    ecc_sync u_sync_a (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .raw_in(phase_a_in),
        .level_out(a_lvl)
    );
    ecc_sync u_sync_b (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .raw_in(phase_b_in),
        .level_out(b_lvl)
    );
    ecc_sync u_sync_idx (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .raw_in(index_in),
        .level_out(idx_lvl)
    );

    // Phase decoding into single-count requests.
    ecc_decoder u_decoder (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .phase_a_in(a_lvl),
        .phase_b_in(b_lvl),
        .mode_in(mode),
        .dir_invert_in(dir_inv),
        .step_if(step_bus)
    );

    // Control field decode.
    assign enable = ctl[POS_ENABLE];
    assign dir_inv = ctl[POS_DIR_INV];
    assign idx_en = ctl[POS_IDX_EN];
    assign idx_act = ctl[POS_IDX_ACT];
    assign idx_inv = ctl[POS_IDX_INV];
    assign limit = ecc_limit_t'(ctl[POS_LIMIT_HI:POS_LIMIT_LO]);
    assign mode = ecc_mode_t'(ctl[POS_MODE_HI:POS_MODE_LO]);

    // Index edge in the chosen polarity; the previous level follows even while disabled.
    // The raw level is kept, so flipping the polarity bit alone never makes a false index.
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            idx_prev <= 1'b0;
        end else begin
            idx_prev <= idx_lvl;
        end
    end
    assign idx_edge = idx_inv ? (idx_prev & ~idx_lvl) : (idx_lvl & ~idx_prev);
    assign idx_hit = enable & idx_en & idx_edge;
    assign cnt_go = enable & step_bus.step & ~frozen;
    assign stepv = ecc_next(count, step_bus.up);
    assign bound = step_bus.up ? preset : CNT_ZERO;

    // Next counter value: channel reset, then index, then counting.
    always_comb begin
        next_count = count;
        next_frozen = frozen;
        if (chan_reset) begin
            next_count = CNT_ZERO;
            next_frozen = 1'b0;
        end else if (idx_hit) begin
            next_count = idx_act ? preset : CNT_ZERO;
        end else if (cnt_go) begin
            case (limit)
                ECC_LIM_WRAP: begin
                    next_count = stepv;
                end
                ECC_LIM_CLAMP: begin
                    if (count != bound) begin
                        next_count = stepv;
                    end
                end
                ECC_LIM_FREEZE: begin
                    if (count == bound) begin
                        next_frozen = 1'b1;
                    end else begin
                        next_count = stepv;
                        next_frozen = (stepv == bound);
                    end
                end
                ECC_LIM_MODN: begin
                    if (step_bus.up) begin
                        next_count = (count == preset) ? CNT_ZERO : stepv;
                    end else begin
                        next_count = (count == CNT_ZERO) ? preset : stepv;
                    end
                end
                default: begin
                    next_count = count;
                end
            endcase
        end
    end

    // Counter state; only a channel reset moves it while disabled, so counting resumes where it stopped.
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            count <= CNT_ZERO;
            frozen <= 1'b0;
            last_up <= 1'b0;
        end else begin
            count <= next_count;
            frozen <= next_frozen;
            if (cnt_go) begin
                last_up <= step_bus.up;
            end
        end
    end

    // APB decode; the slave never waits, so each access takes exactly two cycles.
    assign setup = psel_in & ~penable_in;
    assign access = psel_in & penable_in;
    assign wr = access & pwrite_in;
    assign sel_preset = ecc_hit(paddr_in, IDX_PRESET);
    assign sel_control = ecc_hit(paddr_in, IDX_CONTROL);
    assign sel_count = ecc_hit(paddr_in, IDX_COUNT);
    assign sel_command = ecc_hit(paddr_in, IDX_COMMAND);
    assign mapped = sel_preset | sel_control | sel_count | sel_command;
    assign chan_reset = wr & sel_command & pwdata_in[POS_CMD_RESET];
    assign pready_out = 1'b1;

    // Count register image with the freeze flag and last direction.
    always_comb begin
        status_word = 32'h00000000;
        status_word[CNT_W-1:0] = count;
        status_word[POS_STAT_FROZEN] = frozen;
        status_word[POS_STAT_DIR] = last_up;
    end

    // Read selection; unmapped and command reads return zero.
    assign rd_value = sel_preset ? {8'h00, preset} :
        sel_control ? ctl :
        sel_count ? status_word : 32'h00000000;

    // Register writes take effect in the access cycle only.
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            preset <= PRESET_RESET;
            ctl <= CONTROL_RESET;
        end else if (wr && mapped) begin
            if (sel_preset) begin
                preset <= pwdata_in[CNT_W-1:0];
            end
            if (sel_control) begin
                ctl <= pwdata_in & CONTROL_MASK;
            end
        end
    end

    // Read data and error are captured in setup so they are flop outputs in the access cycle.
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            prdata_out <= 32'h00000000;
            pslverr_out <= 1'b0;
        end else if (setup) begin
            prdata_out <= pwrite_in ? 32'h00000000 : rd_value;
            pslverr_out <= ~mapped;
        end else begin
            pslverr_out <= 1'b0;
        end
    end

    // Helper copies of the filtered phases for the checks below.
    logic a_q;
    logic b_q;
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
        end else begin
            a_q <= a_lvl;
            b_q <= b_lvl;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    // Counting checks.
    a_index_zero: assert property (idx_hit && !idx_act && !chan_reset |=> count == 24'h000000)
        else $error("Index reset did not clear the counter.");
    a_index_preset: assert property (idx_hit && idx_act && !chan_reset |=> count == $past(preset))
        else $error("Index did not load the preset value.");
    a_quad_lead_a: assert property (mode != ECC_MODE_CLKDIR && !a_q && a_lvl && !b_q && !b_lvl
        |-> step_bus.up == !dir_inv)
        else $error("Quadrature direction wrong for A leading B.");
    a_clkdir_dir: assert property (mode == ECC_MODE_CLKDIR && step_bus.step
        |-> step_bus.up == (b_lvl ^ dir_inv))
        else $error("Clock/direction count direction wrong.");
    a_clkdir_edge: assert property (mode == ECC_MODE_CLKDIR && !a_q && a_lvl |-> step_bus.step)
        else $error("Rising A edge gave no count request.");
    a_disabled_hold: assert property (!enable && !chan_reset |=> count == $past(count))
        else $error("Counter moved while disabled.");
    a_enabled_count: assert property (cnt_go && limit == ECC_LIM_WRAP && !idx_hit && !chan_reset
        |=> count != $past(count))
        else $error("Enabled count request did not change the counter.");
    a_wrap_top: assert property (cnt_go && limit == ECC_LIM_WRAP && step_bus.up
        && count == CNT_MAX && !idx_hit && !chan_reset |=> count == 24'h000000)
        else $error("Counter did not wrap from maximum to zero.");
    a_clamp_hold: assert property (cnt_go && limit == ECC_LIM_CLAMP && step_bus.up
        && count == preset && !idx_hit && !chan_reset |=> $stable(count))
        else $error("Clamp mode passed the preset bound.");
    a_freeze_stuck: assert property (frozen && !chan_reset && !idx_hit
        |=> frozen && $stable(count))
        else $error("Frozen counter moved without a channel reset.");
    a_modn_roll: assert property (cnt_go && limit == ECC_LIM_MODN && step_bus.up
        && count == preset && !idx_hit && !chan_reset |=> count == 24'h000000)
        else $error("Modulo-N counter did not roll over to zero.");
    a_quad_single: assert property (mode == ECC_MODE_SINGLE_EDGE_QUAD && step_bus.step
        |-> !a_q && a_lvl && (b_q == b_lvl))
        else $error("Single-edge mode counted on a wrong transition.");
    a_quad_double: assert property (mode == ECC_MODE_DOUBLE_EDGE_QUAD && (a_q != a_lvl)
        && (b_q == b_lvl) |-> step_bus.step)
        else $error("Double-edge mode missed an A change.");
    a_quad_every: assert property (mode == ECC_MODE_QUAD_EDGE_QUAD
        && ((a_q ^ a_lvl) != (b_q ^ b_lvl)) |-> step_bus.step)
        else $error("Four-edge mode missed a state change.");

    // Main scenarios.
    c_modn_roll: cover property (cnt_go && limit == ECC_LIM_MODN && count == preset ##1 count == 24'h000000);
    c_freeze_hit: cover property (!frozen ##1 frozen);
    c_index_load: cover property (idx_hit && idx_act);
    c_clamp_hold: cover property (cnt_go && limit == ECC_LIM_CLAMP && count == bound);

endmodule : ecc_top

// >>> verification/ecc_encoder_model.sv
`timescale 1ns/1ps
// Behavioural incremental encoder; every level is held long enough for the pin filters.
module ecc_encoder_model #(
    parameter int HOLD = 6
) (
    // Pacing clock.
    input wire logic clk_in,
    // Encoder pins.
    output logic phase_a_out,
    output logic phase_b_out,
    output logic index_out
);
    logic [1:0] st = 2'h0;

    // Push-pull encoder outputs start low and are always driven.
    initial begin
        phase_a_out = 1'h0;
        phase_b_out = 1'h0;
        index_out = 1'h0;
    end

    // Gray walk 00, 10, 11, 01: moving up, A leads B.
    task automatic quad(input logic up, input int n);
        for (int i = 0; i < n; i++) begin
            st = up ? st + 2'h1 : st - 2'h1;
            phase_a_out <= st[0] ^ st[1];
            phase_b_out <= st[1];
            repeat (HOLD) @(posedge clk_in);
        end
    endtask : quad

    // Clock pulses on A with the direction level on B; B returns low afterwards.
    task automatic pulses(input logic dir_b, input int n);
        phase_b_out <= dir_b;
        repeat (HOLD) @(posedge clk_in);
        for (int i = 0; i < n; i++) begin
            phase_a_out <= 1'h1;
            repeat (HOLD) @(posedge clk_in);
            phase_a_out <= 1'h0;
            repeat (HOLD) @(posedge clk_in);
        end
        phase_b_out <= 1'h0;
        repeat (HOLD) @(posedge clk_in);
    endtask : pulses

    // One active-high index pulse.
    task automatic index_pulse();
        index_out <= 1'h1;
        repeat (HOLD) @(posedge clk_in);
        index_out <= 1'h0;
        repeat (HOLD) @(posedge clk_in);
    endtask : index_pulse
endmodule : ecc_encoder_model

// >>> verification/ecc_top_tb.sv
`timescale 1ns/1ps
module ecc_top_tb;
    import ecc_pkg::*;

    logic clk_in = 1'h0;
    logic nrst_in = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic phase_a;
    logic phase_b;
    logic index_pin;
    logic [31:0] rd;
    logic err;
    int n_mismatch = 0;
    int checks_done = 0;

    // A 40 MHz clock.
    always #12.5 clk_in = ~clk_in;

    ecc_top dut (.clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .phase_a_in(phase_a),
        .phase_b_in(phase_b), .index_in(index_pin));

    ecc_encoder_model enc (.clk_in(clk_in), .phase_a_out(phase_a), .phase_b_out(phase_b),
        .index_out(index_pin));

    // Verdict and end of run.
    task automatic close_out();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : close_out

    // Word and flag comparisons.
    task automatic cmp_word(input string name, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", name, e, g);
        end
    endtask : cmp_word

    task automatic cmp_flag(input string name, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %b seen %b", name, e, g);
        end
    endtask : cmp_flag

    // One APB transfer; it starts a cycle after entry so releases never collide.
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        int n;
        @(posedge clk_in);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= {idx[5:0], 2'h0};
        pwdata <= wd;
        @(posedge clk_in);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1) begin
            n_mismatch++;
            $display("unexpected pready expected 1 seen %b", pready);
            close_out();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic chk_cnt(input logic [23:0] e);
        apb(1'h0, IDX_COUNT, 32'h00000000);
        cmp_word("count", {8'h00, e}, {8'h00, rd[23:0]});
    endtask : chk_cnt

    function automatic logic [31:0] cw(input logic en, input logic [1:0] lim,
        input logic [1:0] md, input logic inv, input logic ie, input logic ia);
        return {9'h000, ia, 1'h0, ie, inv, en, lim, md, 14'h0000};
    endfunction : cw

    // Preset, control, then a channel reset so every scenario starts from zero.
    task automatic setup(input logic [31:0] ctrl, input logic [23:0] pre);
        apb(1'h1, IDX_PRESET, {8'h00, pre});
        apb(1'h1, IDX_CONTROL, ctrl);
        apb(1'h1, IDX_COMMAND, 32'h00000001);
    endtask : setup

    task automatic t_regs();
        apb(1'h0, IDX_CONTROL, 32'h00000000);
        cmp_word("control reset", CONTROL_RESET, rd);
        apb(1'h0, IDX_PRESET, 32'h00000000);
        cmp_word("preset reset", {8'h00, PRESET_RESET}, rd);
        chk_cnt(CNT_ZERO);
        apb(1'h1, IDX_CONTROL, 32'hFFFFFFFF);
        apb(1'h0, IDX_CONTROL, 32'h00000000);
        cmp_word("control fields", CONTROL_MASK, rd);
        apb(1'h1, IDX_CONTROL, 32'h00000000);
        apb(1'h1, IDX_PRESET, 32'hFFFFFFFF);
        apb(1'h0, IDX_PRESET, 32'h00000000);
        cmp_word("preset width", 32'h00FFFFFF, rd);
        apb(1'h1, IDX_COUNT, 32'h00000055);
        cmp_flag("count write error", 1'h0, err);
        chk_cnt(CNT_ZERO);
        apb(1'h0, 8'h02, 32'h00000000);
        cmp_flag("unmapped error", 1'h1, err);
        cmp_word("unmapped data", 32'h00000000, rd);
    endtask : t_regs

    // Every decode mode in both direction senses, forward then back to zero.
    task automatic t_modes();
        logic [23:0] k;
        for (int m = 0; m < 4; m++) begin
            for (int v = 0; v < 2; v++) begin
                setup(cw(1'h1, 2'h0, m[1:0], v[0], 1'h0, 1'h0), 24'h000000);
                if (m == 0) begin
                    enc.pulses(1'h1, 3);
                    k = 24'h000003;
                end else begin
                    enc.quad(1'h1, 8);
                    k = (m == 1) ? 24'h000002 : (m == 2) ? 24'h000004 : 24'h000008;
                end
                chk_cnt(v[0] ? 24'h000000 - k : k);
                if (m == 0) begin
                    enc.pulses(1'h0, 3);
                end else begin
                    enc.quad(1'h0, 8);
                end
                chk_cnt(CNT_ZERO);
            end
        end
    endtask : t_modes

    task automatic t_limits();
        setup(cw(1'h1, 2'h0, 2'h3, 1'h0, 1'h0, 1'h0), 24'h000005);
        enc.quad(1'h0, 1);
        chk_cnt(CNT_MAX);
        cmp_flag("last direction", 1'h0, rd[POS_STAT_DIR]);
        enc.quad(1'h1, 1);
        chk_cnt(CNT_ZERO);
        cmp_flag("last direction", 1'h1, rd[POS_STAT_DIR]);
        setup(cw(1'h1, 2'h1, 2'h3, 1'h0, 1'h0, 1'h0), 24'h000005);
        enc.quad(1'h1, 8);
        chk_cnt(24'h000005);
        enc.quad(1'h0, 1);
        chk_cnt(24'h000004);
        enc.quad(1'h0, 7);
        chk_cnt(CNT_ZERO);
        setup(cw(1'h1, 2'h2, 2'h3, 1'h0, 1'h0, 1'h0), 24'h000003);
        enc.quad(1'h1, 6);
        chk_cnt(24'h000003);
        cmp_flag("frozen flag", 1'h1, rd[POS_STAT_FROZEN]);
        enc.quad(1'h0, 2);
        chk_cnt(24'h000003);
        apb(1'h1, IDX_COMMAND, 32'h00000001);
        enc.quad(1'h1, 1);
        chk_cnt(24'h000001);
        setup(cw(1'h1, 2'h3, 2'h3, 1'h0, 1'h0, 1'h0), 24'h000003);
        enc.quad(1'h1, 5);
        chk_cnt(24'h000001);
        enc.quad(1'h0, 2);
        chk_cnt(24'h000003);
    endtask : t_limits

    task automatic t_index();
        setup(cw(1'h1, 2'h0, 2'h3, 1'h0, 1'h1, 1'h0), 24'h000009);
        enc.quad(1'h1, 4);
        enc.index_pulse();
        chk_cnt(CNT_ZERO);
        apb(1'h1, IDX_CONTROL, cw(1'h1, 2'h0, 2'h3, 1'h0, 1'h1, 1'h1));
        enc.quad(1'h1, 2);
        enc.index_pulse();
        chk_cnt(24'h000009);
        apb(1'h1, IDX_CONTROL, cw(1'h1, 2'h0, 2'h3, 1'h0, 1'h0, 1'h1));
        enc.quad(1'h1, 2);
        enc.index_pulse();
        chk_cnt(24'h00000B);
        // Active-low index: the pin idles low here, so only its falling edge may load.
        apb(1'h1, IDX_CONTROL, cw(1'h1, 2'h0, 2'h3, 1'h0, 1'h1, 1'h1) | 32'h00200000);
        chk_cnt(24'h00000B);
        enc.index_pulse();
        chk_cnt(24'h000009);
    endtask : t_index

    task automatic t_disable();
        setup(cw(1'h1, 2'h0, 2'h3, 1'h0, 1'h1, 1'h1), 24'h000009);
        enc.quad(1'h1, 3);
        apb(1'h1, IDX_CONTROL, cw(1'h0, 2'h0, 2'h3, 1'h0, 1'h1, 1'h1));
        enc.quad(1'h1, 4);
        enc.index_pulse();
        chk_cnt(24'h000003);
        apb(1'h1, IDX_CONTROL, cw(1'h1, 2'h0, 2'h3, 1'h0, 1'h1, 1'h1));
        enc.quad(1'h1, 2);
        chk_cnt(24'h000005);
    endtask : t_disable

    // Reset for eight cycles, then the scenarios in turn.
    initial begin
        repeat (8) @(posedge clk_in);
        nrst_in <= 1'h1;
        t_regs();
        t_modes();
        t_limits();
        t_index();
        t_disable();
        close_out();
    end

    // A hang anywhere ends the run as a failure.
    initial begin
        repeat (100000) @(posedge clk_in);
        n_mismatch++;
        $display("unexpected run length expected below 100000 cycles seen 100000");
        close_out();
    end
endmodule : ecc_top_tb
